// ---- design/sysctl_regs.vh ----
// Summary of operation
// (RL1) protect bit 0 opens clock register writes
// (RL2) protect bit 3 opens detector/monitor writes
// (RL3) protect bit 6 opens program rom2 writes
// (RL4) closed protect bit keeps register unchanged
// (RL5) enable bit 5 switches detector 0
// (RL6) enable bit 6 switches detector 1
// (RL7) enable bit 7 switches detector 2
// (RL8) eight reset sources are recognised
// (RL9) flag register tells cold or warm start
// (RL10) detectors 1 and 2 raise interrupts
// (RL11) detectors 0, 1, 2 cause resets
// (RL12) each reset source writes its own code into flag bits 2:0
`ifndef SYSCTL_REGS_VH
`define SYSCTL_REGS_VH
`define ADDR_W            8
`define DATA_W            8
`define A_SYSCLK_A        8'h06
`define A_SYSCLK_B        8'h07
`define A_WPROT           8'h0A
`define A_SYSCLK_C        8'h0C
`define A_PCLK_SEL        8'h12
`define A_RST_FLAGS       8'h18
`define A_DET_EN          8'h1A
`define A_PLL             8'h1C
`define A_FAST_OSC        8'h22
`define A_MON_EN          8'h26
`define A_DET1_LVL        8'h28
`define A_MON0            8'h2A
`define A_MON1            8'h2B
`define A_MON2            8'h2C
`define A_PROM2           8'h30
`define A_IRQ_STAT        8'h31
`define A_IRQ_MASK        8'h32
`define WP_CLK_BIT        0
`define WP_VDET_BIT       3
`define WP_PROM2_BIT      6
`define WP_MASK           8'h49
`define DET0_BIT          5
`define DET1_BIT          6
`define DET2_BIT          7
`define CWR_BIT           7
`define SRC_HW            3'h0
`define SRC_VMON0         3'h1
`define SRC_VMON1         3'h2
`define SRC_VMON2         3'h3
`define SRC_POR           3'h4
`define SRC_OSC           3'h5
`define SRC_WDT           3'h6
`define SRC_SW            3'h7
`define ZERO8             8'h00
`endif

// ---- design/reset_cause.v ----
`include "sysctl_regs.vh"
module reset_cause (
  input  wire       mclk_in,
  input  wire       nrst_in,
  input  wire [7:0] src_in,
  input  wire       cold_in,
  output reg  [7:0] flags_out
);
  ////////////////////////////////////////////////////////////////
  // priority: lowest source index wins when several fire together
  function [2:0] first_src;
    input [7:0] v;
    integer i;
    begin
      first_src = `SRC_SW;
      for (i = 7; i >= 0; i = i - 1)
        if (v[i])
          first_src = i[2:0];
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  // flags persist across nrst_in: only a new event rewrites them
  // limitation: contents are undefined until the first reset event
  always @(posedge mclk_in) begin
    if (|src_in) begin
      flags_out[2:0] <= first_src(src_in); // RL12
      flags_out[6:3] <= 4'h0;
      flags_out[`CWR_BIT] <= cold_in; // RL9
    end
  end
endmodule // reset_cause

// ---- design/sysctl_bank.v ----
// The implementer's own choice: the strobed register port.
`include "sysctl_regs.vh"
module sysctl_bank (
  input  wire       mclk_in,
  input  wire       nrst_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire       hw_rst_pin_in,
  input  wire       por_in,
  input  wire       osc_stop_in,
  input  wire       wdt_rst_in,
  input  wire       sw_rst_in,
  input  wire [2:0] below_level_in,
  output reg  [2:0] det_enable_out,
  output reg        sys_reset_out,
  output wire       irq_out,
  output reg  [7:0] sysclk_a_out,
  output reg  [7:0] sysclk_b_out,
  output reg  [7:0] sysclk_c_out,
  output reg  [7:0] pll_out,
  output reg  [7:0] pclk_sel_out,
  output reg  [7:0] fast_osc_out,
  output reg  [7:0] prom2_out,
  output reg  [7:0] mon_en_out,
  output reg  [7:0] det1_lvl_out,
  output reg  [7:0] mon0_out,
  output reg  [7:0] mon1_out,
  output reg  [7:0] mon2_out
);
  reg  [7:0] wprot_reg;
  reg  [7:0] stat_reg;
  reg  [7:0] mask_reg;
  reg  [2:0] lvl_s1_reg;
  reg  [2:0] lvl_s2_reg;
  reg  [4:0] pin_s1_reg;
  reg  [4:0] pin_s2_reg;
  reg  [7:0] rdata_next;
  wire [7:0] flags;
  wire [2:0] low_det;
  wire [7:0] src;
  wire       src_pin;
  wire       src_mon0;
  wire       src_mon1;
  wire       src_mon2;
  wire       src_por;
  wire       src_osc;
  wire       src_wdt;
  wire       src_sw;
  wire       we_wprot;
  wire       we_sysclk_a;
  wire       we_sysclk_b;
  wire       we_sysclk_c;
  wire       we_pll;
  wire       we_pclk_sel;
  wire       we_fast_osc;
  wire       we_prom2;
  wire       we_det_en;
  wire       we_mon_en;
  wire       we_det1_lvl;
  wire       we_mon0;
  wire       we_mon1;
  wire       we_mon2;
  wire       we_mask;
  wire       rs_wprot;
  wire       rs_flags;
  wire       rs_det_en;
  wire       rs_sysclk_a;
  wire       rs_sysclk_b;
  wire       rs_sysclk_c;
  wire       rs_pll;
  wire       rs_pclk_sel;
  wire       rs_fast_osc;
  wire       rs_prom2;
  wire       rs_mon_en;
  wire       rs_det1_lvl;
  wire       rs_mon0;
  wire       rs_mon1;
  wire       rs_mon2;
  wire       rs_stat;
  wire       rs_mask;
  ////////////////////////////////////////////////////////////////
  // async inputs pass two flops before use
  always @(posedge mclk_in) begin
    lvl_s1_reg <= below_level_in;
    lvl_s2_reg <= lvl_s1_reg;
    pin_s1_reg <= {sw_rst_in, wdt_rst_in, osc_stop_in, por_in, hw_rst_pin_in};
    pin_s2_reg <= pin_s1_reg;
  end
  // a disabled detector sees nothing
  assign low_det  = lvl_s2_reg & det_enable_out; // RL11
  assign src_pin  = pin_s2_reg[0];
  assign src_mon0 = low_det[0];
  assign src_mon1 = low_det[1];
  assign src_mon2 = low_det[2];
  assign src_por  = pin_s2_reg[1];
  assign src_osc  = pin_s2_reg[2];
  assign src_wdt  = pin_s2_reg[3];
  assign src_sw   = pin_s2_reg[4];
  assign src = {src_sw, src_wdt, src_osc, src_por,
                src_mon2, src_mon1, src_mon0, src_pin}; // RL8
  ////////////////////////////////////////////////////////////////
  // sys_reset_out asserts for any source; it drives the system reset
  always @(posedge mclk_in) begin
    if (!nrst_in)
      sys_reset_out <= 1'b0;
    else
      sys_reset_out <= |src; // RL11
  end
  // power-on marks cold start; all others are warm
  reset_cause u_cause (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .src_in    (src),
    .cold_in   (src_por),
    .flags_out (flags)
  );
  ////////////////////////////////////////////////////////////////
  wire wp_clk  = wprot_reg[`WP_CLK_BIT];
  wire wp_vdet = wprot_reg[`WP_VDET_BIT];
  wire wp_rom  = wprot_reg[`WP_PROM2_BIT];
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction
  // writes with the guarding bit clear fall through untouched
  assign we_wprot    = wr_in && hit(addr_in, `A_WPROT);
  assign we_sysclk_a = wr_in && hit(addr_in, `A_SYSCLK_A) && wp_clk; // RL1 RL4
  assign we_sysclk_b = wr_in && hit(addr_in, `A_SYSCLK_B) && wp_clk; // RL1
  assign we_sysclk_c = wr_in && hit(addr_in, `A_SYSCLK_C) && wp_clk; // RL1
  assign we_pll      = wr_in && hit(addr_in, `A_PLL) && wp_clk; // RL1
  assign we_pclk_sel = wr_in && hit(addr_in, `A_PCLK_SEL) && wp_clk; // RL1
  assign we_fast_osc = wr_in && hit(addr_in, `A_FAST_OSC) && wp_clk; // RL1
  assign we_prom2    = wr_in && hit(addr_in, `A_PROM2) && wp_rom; // RL3
  assign we_det_en   = wr_in && hit(addr_in, `A_DET_EN) && wp_vdet; // RL2
  assign we_mon_en   = wr_in && hit(addr_in, `A_MON_EN) && wp_vdet; // RL2
  assign we_det1_lvl = wr_in && hit(addr_in, `A_DET1_LVL) && wp_vdet; // RL2
  assign we_mon0     = wr_in && hit(addr_in, `A_MON0) && wp_vdet; // RL2
  assign we_mon1     = wr_in && hit(addr_in, `A_MON1) && wp_vdet; // RL2
  assign we_mon2     = wr_in && hit(addr_in, `A_MON2) && wp_vdet; // RL2
  assign we_mask     = wr_in && hit(addr_in, `A_IRQ_MASK);

  assign rs_wprot    = hit(addr_in, `A_WPROT);
  assign rs_flags    = hit(addr_in, `A_RST_FLAGS);
  assign rs_det_en   = hit(addr_in, `A_DET_EN);
  assign rs_sysclk_a = hit(addr_in, `A_SYSCLK_A);
  assign rs_sysclk_b = hit(addr_in, `A_SYSCLK_B);
  assign rs_sysclk_c = hit(addr_in, `A_SYSCLK_C);
  assign rs_pll      = hit(addr_in, `A_PLL);
  assign rs_pclk_sel = hit(addr_in, `A_PCLK_SEL);
  assign rs_fast_osc = hit(addr_in, `A_FAST_OSC);
  assign rs_prom2    = hit(addr_in, `A_PROM2);
  assign rs_mon_en   = hit(addr_in, `A_MON_EN);
  assign rs_det1_lvl = hit(addr_in, `A_DET1_LVL);
  assign rs_mon0     = hit(addr_in, `A_MON0);
  assign rs_mon1     = hit(addr_in, `A_MON1);
  assign rs_mon2     = hit(addr_in, `A_MON2);
  assign rs_stat     = hit(addr_in, `A_IRQ_STAT);
  assign rs_mask     = hit(addr_in, `A_IRQ_MASK);

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      wprot_reg <= `ZERO8;
    end else if (we_wprot) begin
      wprot_reg <= wdata_in & `WP_MASK;
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      sysclk_a_out <= `ZERO8;
    end else if (we_sysclk_a) begin
      sysclk_a_out <= wdata_in; // RL1
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      sysclk_b_out <= `ZERO8;
    end else if (we_sysclk_b) begin
      sysclk_b_out <= wdata_in; // RL1
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      sysclk_c_out <= `ZERO8;
    end else if (we_sysclk_c) begin
      sysclk_c_out <= wdata_in; // RL1
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      pll_out <= `ZERO8;
    end else if (we_pll) begin
      pll_out <= wdata_in; // RL1
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      pclk_sel_out <= `ZERO8;
    end else if (we_pclk_sel) begin
      pclk_sel_out <= wdata_in; // RL1
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      fast_osc_out <= `ZERO8;
    end else if (we_fast_osc) begin
      fast_osc_out <= wdata_in; // RL1
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      prom2_out <= `ZERO8;
    end else if (we_prom2) begin
      prom2_out <= wdata_in; // RL3
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      det_enable_out <= 3'h0;
    end else if (we_det_en) begin
      det_enable_out[0] <= wdata_in[`DET0_BIT]; // RL5
      det_enable_out[1] <= wdata_in[`DET1_BIT]; // RL6
      det_enable_out[2] <= wdata_in[`DET2_BIT]; // RL7
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mon_en_out <= `ZERO8;
    end else if (we_mon_en) begin
      mon_en_out <= wdata_in; // RL2
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      det1_lvl_out <= `ZERO8;
    end else if (we_det1_lvl) begin
      det1_lvl_out <= wdata_in; // RL2
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mon0_out <= `ZERO8;
    end else if (we_mon0) begin
      mon0_out <= wdata_in; // RL2
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mon1_out <= `ZERO8;
    end else if (we_mon1) begin
      mon1_out <= wdata_in; // RL2
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mon2_out <= `ZERO8;
    end else if (we_mon2) begin
      mon2_out <= wdata_in; // RL2
    end
  end

  // the mask is left open so software can always silence the interrupt
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mask_reg <= `ZERO8;
    end else if (we_mask) begin
      mask_reg <= wdata_in;
    end
  end
  ////////////////////////////////////////////////////////////////
  // interrupt status: bit1 detector1, bit2 detector2; set beats clear
  wire [7:0] irq_set = {5'h00, low_det[2], low_det[1], 1'b0}; // RL10
  wire       clr_hit = wr_in && hit(addr_in, `A_IRQ_STAT);
  always @(posedge mclk_in) begin
    if (!nrst_in)
      stat_reg <= `ZERO8;
    else
      stat_reg <= (stat_reg & ~(clr_hit ? wdata_in : `ZERO8)) | irq_set; // RL10
  end
  assign irq_out = |(stat_reg & mask_reg);
  ////////////////////////////////////////////////////////////////
  // idle and unmapped reads give zero so a stale value never leaks out
  always @* begin
    rdata_next = `ZERO8;
    if (!rd_in) begin
      rdata_next = `ZERO8;
    end else if (rs_wprot) begin
      rdata_next = wprot_reg;
    end else if (rs_flags) begin
      rdata_next = flags; // RL9
    end else if (rs_det_en) begin
      rdata_next = {det_enable_out, 5'h00};
    end else if (rs_sysclk_a) begin
      rdata_next = sysclk_a_out;
    end else if (rs_sysclk_b) begin
      rdata_next = sysclk_b_out;
    end else if (rs_sysclk_c) begin
      rdata_next = sysclk_c_out;
    end else if (rs_pll) begin
      rdata_next = pll_out;
    end else if (rs_pclk_sel) begin
      rdata_next = pclk_sel_out;
    end else if (rs_fast_osc) begin
      rdata_next = fast_osc_out;
    end else if (rs_prom2) begin
      rdata_next = prom2_out;
    end else if (rs_mon_en) begin
      rdata_next = mon_en_out;
    end else if (rs_det1_lvl) begin
      rdata_next = det1_lvl_out;
    end else if (rs_mon0) begin
      rdata_next = mon0_out;
    end else if (rs_mon1) begin
      rdata_next = mon1_out;
    end else if (rs_mon2) begin
      rdata_next = mon2_out;
    end else if (rs_stat) begin
      rdata_next = stat_reg;
    end else if (rs_mask) begin
      rdata_next = mask_reg;
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_out <= `ZERO8;
    end else begin
      rdata_out <= rdata_next;
    end
  end
endmodule // sysctl_bank

// ---- tb/sysctl_bank_assertions.sv ----
`include "sysctl_regs.vh"
module sysctl_bank_assertions (
  input wire       mclk_in,
  input wire       nrst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       hw_rst_pin_in,
  input wire [2:0] below_level_in,
  input wire [2:0] det_enable_out,
  input wire       sys_reset_out,
  input wire       irq_out,
  input wire [7:0] sysclk_a_out,
  input wire [7:0] prom2_out,
  input wire [7:0] mon0_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // shadow of the protect gate, rebuilt from the writes seen on the port
  reg  [7:0] wp_reg;
  wire       w_clk = wr_in && addr_in == `A_SYSCLK_A;
  always @(posedge mclk_in) begin
    if (!nrst_in)
      wp_reg <= `ZERO8;
    else if (wr_in && addr_in == `A_WPROT)
      wp_reg <= wdata_in & `WP_MASK;
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_clk_open; w_clk && wp_reg[0] |=> sysclk_a_out == $past(wdata_in); endproperty
  a_clk_open: assert property (p_clk_open) else $error("clock write lost");
  property p_clk_shut; w_clk && !wp_reg[0] |=> $stable(sysclk_a_out); endproperty
  a_clk_shut: assert property (p_clk_shut) else $error("locked write landed");
  property p_mon0; wr_in && addr_in == `A_MON0 && wp_reg[3] |=> mon0_out == $past(wdata_in);
  endproperty
  a_mon0: assert property (p_mon0) else $error("monitor write lost");
  property p_prom2; wr_in && addr_in == `A_PROM2 && wp_reg[6] |=> prom2_out == $past(wdata_in);
  endproperty
  a_prom2: assert property (p_prom2) else $error("rom2 write lost");
  property p_det; wr_in && addr_in == `A_DET_EN && wp_reg[3]
    |=> {det_enable_out, 5'h00} == ($past(wdata_in) & 8'hE0); endproperty
  a_det: assert property (p_det) else $error("detector enables wrong");
  property p_det_rd; rd_in && addr_in == `A_DET_EN |=> rdata_out[7:5] == $past(det_enable_out);
  endproperty
  a_det_rd: assert property (p_det_rd) else $error("detector readback wrong");
  // pin path is two sync flops plus the output flop
  property p_pin; hw_rst_pin_in |-> ##[1:4] sys_reset_out; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missing");
  property p_detect_level_zero; below_level_in[0] && det_enable_out[0] |-> ##[1:4] sys_reset_out; endproperty
  a_detect_level_zero: assert property (p_detect_level_zero) else $error("detector reset missing");
  property p_irq_rst; $rose(nrst_in) |-> !irq_out; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
endmodule // sysctl_bank_assertions
bind sysctl_bank sysctl_bank_assertions u_sysctl_bank_assertions (.mclk_in(mclk_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .hw_rst_pin_in(hw_rst_pin_in), .below_level_in(below_level_in),
  .det_enable_out(det_enable_out), .sys_reset_out(sys_reset_out), .irq_out(irq_out),
  .sysclk_a_out(sysclk_a_out), .prom2_out(prom2_out), .mon0_out(mon0_out));

// ---- tb/sysctl_bank_tb.sv ----
`include "sysctl_regs.vh"
module sysctl_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
  reg        mclk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  reg  [7:0] addr_in = 8'h00, wdata_in = 8'h00, d, g;
  reg  [4:0] rs = 5'h00;
  reg  [2:0] below = 3'h0;
  wire [7:0] rdata;
  wire [2:0] det_en;
  wire       sys_rst, irq;
  int        n_errors = 0, checks_done = 0;
  reg  [7:0] ga [12] = '{`A_SYSCLK_A, `A_SYSCLK_B, `A_SYSCLK_C, `A_PLL, `A_PCLK_SEL,
    `A_FAST_OSC, `A_MON_EN, `A_DET1_LVL, `A_MON0, `A_MON1, `A_MON2, `A_PROM2};
  always #5 mclk_in = ~mclk_in;
  sysctl_bank u_sysctl_bank (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .hw_rst_pin_in(rs[0]), .por_in(rs[1]), .osc_stop_in(rs[2]), .wdt_rst_in(rs[3]),
    .sw_rst_in(rs[4]), .below_level_in(below), .det_enable_out(det_en),
    .sys_reset_out(sys_rst), .irq_out(irq), .sysclk_a_out(), .sysclk_b_out(),
    .sysclk_c_out(), .pll_out(), .pclk_sel_out(), .fast_osc_out(), .prom2_out(),
    .mon_en_out(), .det1_lvl_out(), .mon0_out(), .mon1_out(), .mon2_out());
  //////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    `CHK("rdata", e & m, rdata & m)
  endtask
  // one reset event per source code; the flag is read once the pulse has passed
  task fire(input [2:0] c);
    int t;
    @(posedge mclk_in);
    if (c inside {[1:3]}) below <= 3'h1 << (c - 1);
    else rs <= 5'h01 << (c == 0 ? 0 : c - 3);
    for (t = 0; t < 8 && sys_rst !== 1'b1; t++) @(posedge mclk_in) #1;
    `CHK("sys_reset", 1'b1, sys_rst)
    @(posedge mclk_in);
    below <= 3'h0;
    rs <= 5'h00;
    repeat (6) @(posedge mclk_in);
    rd(`A_RST_FLAGS, {c == 4, 4'h0, c}, 8'h87);
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(90));
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    wr(`A_WPROT, 8'hFF);
    rd(`A_WPROT, `WP_MASK, 8'hFF);
    for (int j = 0; j < 4; j++) begin
      d = j < 3 ? 8'h20 << j : $urandom;
      wr(`A_DET_EN, d);
      `CHK("det_en", d[7:5], det_en)
    end
    wr(`A_WPROT, 8'h41);
    wr(`A_DET_EN, ~d);
    `CHK("det_en", d[7:5], det_en)
    // other gate bits open while the guarding bit is shut: the awkward case
    for (int i = 0; i < 12; i++) begin
      g = i < 6 ? 8'h01 : (i < 11 ? 8'h08 : 8'h40);
      d = $urandom;
      wr(`A_WPROT, ~g & `WP_MASK);
      wr(ga[i], d);
      rd(ga[i], 8'h00, 8'hFF);
      wr(`A_WPROT, g);
      wr(ga[i], d);
      rd(ga[i], d, 8'hFF);
    end
    rd(8'hFF, 8'h00, 8'hFF);
    wr(`A_WPROT, 8'h08);
    wr(`A_DET_EN, 8'hE0);
    rd(`A_DET_EN, 8'hE0, 8'hE0);
    wr(`A_IRQ_MASK, 8'h00);
    @(posedge mclk_in);
    below <= 3'h2;
    repeat (6) @(posedge mclk_in);
    below <= 3'h0;
    #1 `CHK("irq", 1'b0, irq)
    wr(`A_IRQ_MASK, 8'h02);
    `CHK("irq", 1'b1, irq)
    wr(`A_IRQ_STAT, 8'h02);
    `CHK("irq", 1'b0, irq)
    for (int c = 0; c < 8; c++) fire(c[2:0]);
    // mid-run reset: cause survives, protect gate closes again
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rd(`A_RST_FLAGS, {1'b0, 4'h0, `SRC_SW}, 8'h87);
    rd(`A_WPROT, 8'h00, 8'hFF);
    test_done;
  end
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule // sysctl_bank_tb
